// *** common/t16c_pkg.sv ***
package t16c_pkg;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_FORCE  = 8'h04;
   localparam logic [7:0] OFF_COUNT  = 8'h08;
   localparam logic [7:0] OFF_CMPA   = 8'h0c;
   localparam logic [7:0] OFF_CMPB   = 8'h10;
   localparam logic [7:0] OFF_CAPT   = 8'h14;
   localparam logic [7:0] OFF_FLAGS  = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACT_LSB  = 4;
   localparam int CTRL_DIV_LSB  = 8;
   localparam int CTRL_RUN_BIT  = 16;

   localparam int FLAG_OVF_BIT  = 0;
   localparam int FLAG_CMP_LSB  = 1;

   localparam logic [16:0] CTRL_RESET  = 17'h00000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] REG_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [15:0] COUNT_BOT   = 16'h0000;
   localparam logic [1:0]  WAVE_RESET  = 2'h0;

   localparam logic [3:0] MODE_NORMAL   = 4'h0;
   localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPT = 4'hc;

   typedef enum logic [1:0]
   {
      T16C_ACT_NONE   = 2'h0,
      T16C_ACT_TOGGLE = 2'h1,
      T16C_ACT_CLEAR  = 2'h2,
      T16C_ACT_SET    = 2'h3
   } t16c_action_type;
endpackage

// *** rtl/t16c_timer.sv ***
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module t16c_timer
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // apb slave
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // port pin logic, one bit per compare channel, and a single-bit overflow_ack
   input  wire logic [1:0] port_data,
   input  wire logic [1:0] waveform_pin_direction,
   input  wire logic       overflow_ack,
   output logic [1:0]      pin_out,
   output logic [1:0]      pin_oe
);
   import t16c_pkg::*;

   logic [16:0] ctrl;
   logic [15:0] counter_value;
   logic [15:0] compare_register [2];
   logic [15:0] capture_register;
   logic        overflow_flag;
   logic [1:0]  compare_match_flag;
   logic [1:0]  waveform_output_bit;
   logic        match_block;
   logic [7:0]  div_count;

   logic [16:0] next_ctrl;
   logic [15:0] next_counter_value;
   logic [15:0] next_compare_register [2];
   logic [15:0] next_capture_register;
   logic        next_overflow_flag;
   logic [1:0]  next_compare_match_flag;
   logic [1:0]  next_waveform_output_bit;
   logic        next_match_block;
   logic [7:0]  next_div_count;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic [1:0]  next_pin_out;
   logic [1:0]  next_pin_oe;

   logic        access;
   logic        wr;
   logic        mapped;
   logic        tick;
   logic [3:0]  mode;
   logic        pwm;
   logic [15:0] top;
   logic        at_top;
   logic [1:0]  match;
   logic [1:0]  force_hit;
   logic [1:0]  action [2];

   function automatic logic is_pwm(input logic [3:0] m);
      return !(m == MODE_NORMAL || m == MODE_CTC_CMPA || m == MODE_CTC_CAPT);
   endfunction

   // result of one compare event on a waveform bit
   function automatic logic apply_action(input logic cur, input logic [1:0] act,
                                         input logic pwm_mode);
      logic r;
      r = cur;
      if (!pwm_mode)
      begin
         case (t16c_action_type'(act))
            T16C_ACT_NONE:   r = cur;
            T16C_ACT_TOGGLE: r = !cur;
            T16C_ACT_CLEAR:  r = 1'b0;
            T16C_ACT_SET:    r = 1'b1;
            default:         r = cur;
         endcase
      end
      else
      begin
         // pwm: code 2 non-inverted, 3 inverted; 1 reserved, no effect
         case (t16c_action_type'(act))
            T16C_ACT_CLEAR:  r = 1'b1;
            T16C_ACT_SET:    r = 1'b0;
            default:         r = cur;
         endcase
      end
      return r;
   endfunction

   always_comb
   begin
      access = psel && penable && pready;
      wr     = access && pwrite;
      mapped = paddr[1:0] == 2'h0 && paddr <= OFF_STATUS;
      mode   = ctrl[CTRL_MODE_LSB +: 4];
      pwm    = is_pwm(mode);
      action[0] = ctrl[CTRL_ACT_LSB +: 2];
      action[1] = ctrl[CTRL_ACT_LSB + 2 +: 2];
      tick   = ctrl[CTRL_RUN_BIT] && div_count == ctrl[CTRL_DIV_LSB +: 8];
      // top comes from compare A or capture register in clear-on-match mode
      top    = (mode == MODE_CTC_CAPT) ? capture_register : compare_register[0];
      at_top = (mode == MODE_CTC_CMPA || mode == MODE_CTC_CAPT) && counter_value == top;

      next_ctrl               = ctrl;
      next_counter_value      = counter_value;
      next_compare_register   = compare_register;
      next_capture_register   = capture_register;
      next_overflow_flag      = overflow_flag;
      next_compare_match_flag = compare_match_flag;
      next_waveform_output_bit = waveform_output_bit;
      next_match_block        = match_block;
      next_div_count          = (tick || !ctrl[CTRL_RUN_BIT]) ? 8'h00 : div_count + 8'h01;

      // apb answer: one wait cycle, pready high for one cycle
      next_pready  = psel && penable && !pready;
      next_pslverr = psel && penable && !pready && !mapped;
      next_prdata  = 32'h00000000;
      if (psel && penable && !pready && !pwrite)
      begin
         case (paddr)
            OFF_CTRL:   next_prdata = {15'h0000, ctrl};
            OFF_COUNT:  next_prdata = {16'h0000, counter_value};
            OFF_CMPA:   next_prdata = {16'h0000, compare_register[0]};
            OFF_CMPB:   next_prdata = {16'h0000, compare_register[1]};
            OFF_CAPT:   next_prdata = {16'h0000, capture_register};
            OFF_FLAGS:  next_prdata = {29'h00000000, compare_match_flag, overflow_flag};
            OFF_STATUS: next_prdata = {28'h0000000, pin_out, waveform_output_bit};
            default:    next_prdata = 32'h00000000;
         endcase
      end

      // software clears first, so hardware sets below win
      if (wr && paddr == OFF_FLAGS)
      begin
         if (pwdata[FLAG_OVF_BIT])
            next_overflow_flag = 1'b0;
         next_compare_match_flag = compare_match_flag & ~pwdata[FLAG_CMP_LSB +: 2];
      end
      if (overflow_ack)
         next_overflow_flag = 1'b0;

      // forced compare only in non-pwm modes
      force_hit = (wr && paddr == OFF_FORCE && !pwm) ? pwdata[1:0] : 2'h0;

      for (int i = 0; i < 2; i++)
      begin
         match[i] = tick && !match_block && counter_value == compare_register[i];
         if (match[i])
            next_compare_match_flag[i] = 1'b1;
         // match and force in one cycle act once; force sets no flag
         if (match[i] || force_hit[i])
            next_waveform_output_bit[i] =
               apply_action(waveform_output_bit[i], action[i], pwm);
         else if (pwm && tick && counter_value == COUNT_MAX && action[i][1])
            next_waveform_output_bit[i] = !action[i][0];
      end

      if (tick)
      begin
         next_match_block = 1'b0;
         if (at_top)
            next_counter_value = COUNT_BOT;
         else
            next_counter_value = counter_value + 16'h0001;
         if (counter_value == COUNT_MAX)
            next_overflow_flag = 1'b1;
      end

      if (wr)
      begin
         case (paddr)
            OFF_CTRL:  next_ctrl = pwdata[16:0];
            OFF_COUNT:
            begin
               // counter write wins over a tick and masks the next match
               next_counter_value = pwdata[15:0];
               next_match_block   = 1'b1;
            end
            OFF_CMPA:  next_compare_register[0] = pwdata[15:0];
            OFF_CMPB:  next_compare_register[1] = pwdata[15:0];
            OFF_CAPT:  next_capture_register    = pwdata[15:0];
            default:   next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ctrl                <= CTRL_RESET;
         counter_value       <= COUNT_RESET;
         compare_register[0] <= REG_RESET;
         compare_register[1] <= REG_RESET;
         capture_register    <= REG_RESET;
         overflow_flag       <= 1'b0;
         compare_match_flag  <= 2'h0;
         waveform_output_bit <= WAVE_RESET;
         match_block         <= 1'b0;
         div_count           <= 8'h00;
         prdata              <= 32'h00000000;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
      end
      else
      begin
         ctrl                <= next_ctrl;
         counter_value       <= next_counter_value;
         compare_register    <= next_compare_register;
         capture_register    <= next_capture_register;
         overflow_flag       <= next_overflow_flag;
         compare_match_flag  <= next_compare_match_flag;
         waveform_output_bit <= next_waveform_output_bit;
         match_block         <= next_match_block;
         div_count           <= next_div_count;
         prdata              <= next_prdata;
         pready              <= next_pready;
         pslverr             <= next_pslverr;
      end
   end

   // pin source per channel; direction always from the port
   for (genvar g = 0; g < 2; g++)
   begin : g_pin
      always_comb
      begin
         next_pin_out[g] = (action[g] != 2'h0) ? waveform_output_bit[g]
                                               : port_data[g];
         next_pin_oe[g]  = waveform_pin_direction[g];
      end

      always_ff @(posedge clock)
      begin
         if (reset)
         begin
            pin_out[g] <= 1'b0;
            pin_oe[g]  <= 1'b0;
         end
         else
         begin
            pin_out[g] <= next_pin_out[g];
            pin_oe[g]  <= next_pin_oe[g];
         end
      end
   end

   sequence force_write_s;
      wr && paddr == OFF_FORCE && pwdata[0] && !pwm;
   endsequence

   sequence quiet_match_s;
      !match[0] && !(wr && paddr == OFF_FLAGS);
   endsequence

   sequence count_write_s;
      wr && paddr == OFF_COUNT;
   endsequence

   chk_reset_wave: assert property (@(posedge clock) $fell(reset) |->
      waveform_output_bit == 2'h0) else $error("waveform bit not cleared by reset");

   chk_pin_source: assert property (@(posedge clock) disable iff (reset)
      1'b1 |=> pin_out[0] == ($past(action[0]) != 2'h0 ? $past(waveform_output_bit[0])
                                                       : $past(port_data[0])))
      else $error("pin source wrong");

   chk_pin_dir: assert property (@(posedge clock) disable iff (reset)
      1'b1 |=> pin_oe == $past(waveform_pin_direction)) else $error("pin direction wrong");

   chk_hold_none: assert property (@(posedge clock) disable iff (reset)
      match[0] && action[0] == 2'h0 |=> $stable(waveform_output_bit[0]))
      else $error("action zero changed waveform bit");

   chk_toggle_match: assert property (@(posedge clock) disable iff (reset)
      match[0] && !pwm && action[0] == 2'h1
      |=> waveform_output_bit[0] != $past(waveform_output_bit[0]))
      else $error("toggle missing");

   chk_force_noflag: assert property (@(posedge clock) disable iff (reset)
      force_write_s ##0 quiet_match_s ##0 !compare_match_flag[0]
      |=> !compare_match_flag[0]) else $error("force set compare flag");

   chk_force_set: assert property (@(posedge clock) disable iff (reset)
      force_write_s ##0 action[0] == 2'h3 |=> waveform_output_bit[0])
      else $error("force did not set output");

   chk_normal_wrap: assert property (@(posedge clock) disable iff (reset)
      tick && mode == MODE_NORMAL && counter_value == COUNT_MAX && !wr
      |=> counter_value == COUNT_BOT && overflow_flag) else $error("normal wrap wrong");

   chk_ctc_clear: assert property (@(posedge clock) disable iff (reset)
      tick && mode == MODE_CTC_CMPA && counter_value == compare_register[0] && !wr
      |=> counter_value == COUNT_BOT) else $error("clear-on-match failed");

   chk_match_flag: assert property (@(posedge clock) disable iff (reset)
      match[0] |=> compare_match_flag[0]) else $error("compare flag not set");

   chk_force_pwm: assert property (@(posedge clock) disable iff (reset)
      wr && paddr == OFF_FORCE && pwdata[0] && pwm && !tick
      |=> $stable(waveform_output_bit[0])) else $error("force acted in pwm mode");

   chk_count_write: assert property (@(posedge clock) disable iff (reset)
      count_write_s |=> counter_value == $past(pwdata[15:0]))
      else $error("counter write lost");

   chk_count_block: assert property (@(posedge clock) disable iff (reset)
      count_write_s ##1 tick |-> match == 2'h0) else $error("match after counter write");
endmodule

// *** verification/t16c_port_model.sv ***
`timescale 1ns/1ps
module t16c_port_model
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // software side of the port
   input  wire logic       load,
   input  wire logic [1:0] load_data,
   input  wire logic [1:0] load_dir,
   // timer side
   output logic [1:0]      port_data,
   output logic [1:0]      waveform_pin_direction,
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   // resolved pad level, pulled up when undriven
   output logic [1:0]      pin_level
);
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         port_data              <= 2'h0;
         waveform_pin_direction <= 2'h0;
      end
      else if (load)
      begin
         port_data              <= load_data;
         waveform_pin_direction <= load_dir;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
      end
   end
endmodule

// *** verification/timer16_compare_output_normal_ctc_test.sv ***
`timescale 1ns/1ps
module timer16_compare_output_normal_ctc_test;
   import t16c_pkg::*;
   typedef struct { logic [31:0] exp; logic [31:0] mask; logic err; } t16c_note_type;
   logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, overflow_ack = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, load = 0;
   logic [1:0] load_data = 2'h0, load_dir = 2'h0, port_data, pin_dir, pin_out, pin_oe, pin_level;
   int num_errors = 0, num_checks = 0;
   t16c_note_type notes[$];

   always #2.5 clock = ~clock;

   t16c_timer u_t16c_timer (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_data(port_data), .waveform_pin_direction(pin_dir),
      .overflow_ack(overflow_ack), .pin_out(pin_out), .pin_oe(pin_oe));
   t16c_port_model u_t16c_port_model (.clock(clock), .reset(reset), .load(load),
      .load_data(load_data), .load_dir(load_dir), .port_data(port_data),
      .waveform_pin_direction(pin_dir), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_level(pin_level));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1);
      chk("pready wait", 32'h2, 32'(n));
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic r);
      notes.push_back('{e & m, m, r});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic port(input logic [1:0] d, input logic [1:0] dir);
      @(posedge clock);
      load <= 1'b1; load_data <= d; load_dir <= dir;
      @(posedge clock);
      load <= 1'b0;
   endtask

   // read results are compared in order against the queued notes
   always @(posedge clock)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (notes.size() == 0) chk("note queue", 32'h1, 32'h0);
         else
         begin
            t16c_note_type nt;
            nt = notes.pop_front();
            chk("prdata", nt.exp, prdata & nt.mask);
            chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
         end
      end
   end

   task automatic test_done;
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      num_errors++;
      test_done();
   end

   initial
   begin
      static logic [1:0] acts[5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
      static logic [3:0] modes[2] = '{MODE_CTC_CMPA, MODE_CTC_CAPT};
      static logic [7:0] topreg[2] = '{OFF_CMPA, OFF_CAPT};
      static logic [15:0] tops[2] = '{16'h0003, 16'h0007};
      logic w;
      logic [1:0] a, pd;
      void'($urandom(32'hbb2886f5));
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      rd(OFF_STATUS, 32'h0, 32'hffffffff, 1'b0);
      rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
      rd(8'h02, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, OFF_COUNT, 32'h1234);
      for (int ch = 0; ch < 2; ch++)
      begin
         w = 1'b0;
         for (int i = 0; i < 5; i++)
         begin
            a = acts[i];
            pd = 2'($urandom);
            port(pd, 2'(1 << ch));
            apb(1'b1, OFF_CTRL, 32'(a) << (CTRL_ACT_LSB + 2 * ch));
            rd(OFF_STATUS, 32'(w) << ch, 32'h1 << ch, 1'b0);
            apb(1'b1, OFF_FORCE, 32'h1 << ch);
            w = (a == 2'h0) ? w : (a == 2'h1) ? ~w : a[0];
            rd(OFF_STATUS, 32'(w) << ch, 32'h1 << ch, 1'b0);
            repeat (3) @(posedge clock);
            chk("pin_out", 32'((a != 2'h0) ? w : pd[ch]), 32'(pin_out[ch]));
            chk("pin_level", 32'((a != 2'h0) ? w : pd[ch]), 32'(pin_level[ch]));
            chk("pin_oe", 32'(1 << ch), 32'(pin_oe));
         end
         rd(OFF_FLAGS, 32'h0, 32'h6, 1'b0);
         rd(OFF_COUNT, 32'h1234, 32'hffff, 1'b0);
      end
      // pwm-style mode: force strobe is ignored, channel a bit stays low
      apb(1'b1, OFF_CTRL, 32'h5 | (32'h3 << CTRL_ACT_LSB));
      apb(1'b1, OFF_FORCE, 32'h1);
      rd(OFF_STATUS, 32'h0, 32'h1, 1'b0);
      port(2'h0, 2'h0);
      repeat (3) @(posedge clock);
      chk("pin_level", 32'h3, 32'(pin_level));
      // normal mode: counter written while running, then wraps
      apb(1'b1, OFF_FLAGS, 32'h7);
      apb(1'b1, OFF_CTRL, 32'h1 << CTRL_RUN_BIT);
      apb(1'b1, OFF_COUNT, 32'hfff0);
      repeat (40) @(posedge clock);
      apb(1'b1, OFF_CTRL, 32'h0);
      rd(OFF_FLAGS, 32'h1, 32'h1, 1'b0);
      rd(OFF_COUNT, 32'h0, 32'hff00, 1'b0);
      @(posedge clock);
      overflow_ack <= 1'b1;
      @(posedge clock);
      overflow_ack <= 1'b0;
      rd(OFF_FLAGS, 32'h0, 32'h1, 1'b0);
      // clear-on-match from compare A and from capture register
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, OFF_CMPA, 32'h100);
         apb(1'b1, topreg[m], 32'(tops[m]));
         apb(1'b1, OFF_COUNT, 32'h0);
         apb(1'b1, OFF_FLAGS, 32'h7);
         // channel a toggles on each match while the counter runs
         apb(1'b1, OFF_CTRL, (32'h1 << CTRL_RUN_BIT) | (32'h1 << CTRL_ACT_LSB)
             | 32'(modes[m]));
         repeat (40) @(posedge clock);
         apb(1'b1, OFF_CTRL, 32'h0);
         rd(OFF_COUNT, 32'h0, ~32'(tops[m]), 1'b0);
         rd(OFF_FLAGS, (m == 0) ? 32'h2 : 32'h0, 32'h3, 1'b0);
      end
      repeat (4) @(posedge clock);
      if (notes.size() != 0) chk("note queue", 32'h0, 32'(notes.size()));
      test_done();
   end
endmodule
